// ### csmc_pkg.sv
// Package for the clock source mode control block: register map, field
// layouts, reset values, mode codes and timing counts.
// Assumes a single 250 MHz system clock and 32-bit Avalon-MM register access.
package csmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [3:0] CSMC_ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] CSMC_ADDR_CTRL2 = 4'h4;
  localparam logic [3:0] CSMC_ADDR_TRIM = 4'h8;
  localparam logic [3:0] CSMC_ADDR_STAT = 4'hc;

  // Reset values: loop output, divide by 1, internal reference, bus divide by 2
  localparam logic [7:0] CSMC_CTRL1_RST = 8'h04;
  localparam logic [7:0] CSMC_CTRL2_RST = 8'h40;
  localparam logic [1:0] CSMC_STATUS_RST = 2'h0;

  // Source select and mode status codes
  localparam logic [1:0] CSMC_SRC_LOOP = 2'h0;
  localparam logic [1:0] CSMC_SRC_IREF = 2'h1;
  localparam logic [1:0] CSMC_SRC_EREF = 2'h2;
  localparam logic [1:0] CSMC_SRC_RSVD = 2'h3;

  // One-hot source vector order: loop, internal, external
  localparam logic [2:0] CSMC_SEL_LOOP = 3'h1;
  localparam logic [2:0] CSMC_SEL_IREF = 3'h2;
  localparam logic [2:0] CSMC_SEL_EREF = 3'h4;

  // Timing
  localparam int CSMC_CLK_MHZ = 250;
  localparam int CSMC_SWITCH_TIMEOUT_NS = 4000;
  localparam logic [10:0] CSMC_SWITCH_TIMEOUT_CYC = 11'((CSMC_SWITCH_TIMEOUT_NS * CSMC_CLK_MHZ) / 1000);
  localparam logic [2:0] CSMC_SWITCH_EDGES = 3'h4;
  localparam logic [2:0] CSMC_RELOCK_EDGES = 3'h4;
  localparam logic [9:0] CSMC_LOOP_MULT = 10'h200;
  localparam int CSMC_OSC_INIT_DEFAULT = 4096;

  // Control register 1 layout
  typedef struct packed {
    logic [1:0] src_sel;
    logic [2:0] ref_div;
    logic int_ref_sel;
    logic int_out_en;
    logic int_stop_en;
  } csmc_ctrl1_t;

  // Control register 2 layout
  typedef struct packed {
    logic [1:0] bus_div;
    logic range_sel;
    logic high_gain;
    logic loop_pd;
    logic osc_req;
    logic ext_out_en;
    logic ext_stop_en;
  } csmc_ctrl2_t;

  // Status and fine trim register layout
  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] mode_status;
    logic osc_ready;
    logic fine_period;
  } csmc_stat_t;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    CSMC_LOOP_INT = 6'h01,
    CSMC_LOOP_EXT = 6'h02,
    CSMC_BYP_INT = 6'h04,
    CSMC_BYP_INT_LP = 6'h08,
    CSMC_BYP_EXT = 6'h10,
    CSMC_BYP_EXT_LP = 6'h20
  } csmc_mode_t;

  // Clock switch states, one-hot
  typedef enum logic [1:0] {
    CSMC_SW_IDLE = 2'h1,
    CSMC_SW_WAIT = 2'h2
  } csmc_sw_state_t;

endpackage : csmc_pkg

// ### csmc_clk_switch.sv
// Glitch-free three-way clock selector for the core clock path.
// Assumes all source clocks arrive as levels sampled on the system clock.
`timescale 1ns/1ps
module csmc_clk_switch (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] src,
  input wire logic [2:0] req,
  output logic clk_out,
  output logic [2:0] cur
);

  csmc_pkg::csmc_sw_state_t state_reg;
  csmc_pkg::csmc_sw_state_t state_next;
  logic [2:0] cur_reg;
  logic [2:0] cur_next;
  logic [2:0] pend_reg;
  logic [2:0] pend_next;
  logic [2:0] src_prev_reg;
  logic [2:0] edge_cnt_reg;
  logic [2:0] edge_cnt_next;
  logic [10:0] tmo_reg;
  logic [10:0] tmo_next;
  logic out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Levels and edges of the old and pending sources
  wire logic new_lvl = |(src & pend_reg);
  wire logic old_lvl = |(src & cur_reg);
  wire logic new_rise = |(src & ~src_prev_reg & pend_reg);
  wire logic enough = (edge_cnt_reg >= csmc_pkg::CSMC_SWITCH_EDGES);
  wire logic timed_out = (tmo_reg == csmc_pkg::CSMC_SWITCH_TIMEOUT_CYC);

  // Next-state logic of the switch sequencer
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    pend_next = pend_reg;
    edge_cnt_next = edge_cnt_reg;
    tmo_next = tmo_reg;
    unique case (state_reg)
      csmc_pkg::CSMC_SW_IDLE: begin
        if (req != cur_reg) begin
          pend_next = req;
          edge_cnt_next = '0;
          tmo_next = '0;
          state_next = csmc_pkg::CSMC_SW_WAIT;
        end
      end
      csmc_pkg::CSMC_SW_WAIT: begin
        if (req != pend_reg) begin
          // Request moved on: restart toward the latest choice
          pend_next = req;
          edge_cnt_next = '0;
          tmo_next = '0;
          if (req == cur_reg) begin
            state_next = csmc_pkg::CSMC_SW_IDLE;
          end
        // move after new edges, both low
        end else if (enough && !new_lvl && !old_lvl) begin
          cur_next = pend_reg;
          state_next = csmc_pkg::CSMC_SW_IDLE;
        end else if (timed_out) begin
          edge_cnt_next = '0;
          tmo_next = '0;
        end else begin
          tmo_next = tmo_reg + 11'h1;
          if (new_rise && !enough) begin
            edge_cnt_next = edge_cnt_reg + 3'h1;
          end
        end
      end
    endcase
  end

  // State registers; reset selects the loop output
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= csmc_pkg::CSMC_SW_IDLE;
      cur_reg <= csmc_pkg::CSMC_SEL_LOOP;
      pend_reg <= csmc_pkg::CSMC_SEL_LOOP;
      edge_cnt_reg <= '0;
      tmo_reg <= '0;
      src_prev_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pend_reg <= pend_next;
      edge_cnt_reg <= edge_cnt_next;
      tmo_reg <= tmo_next;
      src_prev_reg <= src;
      out_reg <= |(src & cur_next);
    end
  end

  assign clk_out = out_reg;
  assign cur = cur_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  no_early_switch_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == csmc_pkg::CSMC_SW_WAIT && !enough) |=> $stable(cur_reg))
    else $error("clock switched before enough new edges");
  switch_when_low_a: assert property (@(posedge clock) disable iff (rst)
    (cur_reg != $past(cur_reg)) |-> !$past(old_lvl) && !$past(new_lvl))
    else $error("clock switched while a source was high");

endmodule : csmc_clk_switch

// ### csmc_top.sv
// Clock source mode control: registers, mode decode, reference dividers,
// oscillator ready flag, stop gating and bus clock divider.
// Assumes source clocks and control pins are synchronous levels on CLOCK and
// the frequency-locked loop itself lives outside, steered by the FLL_ ports.
`timescale 1ns/1ps

// Function
// - mode status shows clock in effect
// - status follows only after synchronised switch
// - oscillator flag sets after startup cycles
// - oscillator flag clears only on enable drop
// - fine bit lengthens period when set
// - reset gives loop engaged internal mode
// - loop locks at 512 times filter
// - 00 with external reference: loop external
// - 01 internal, loop kept running
// - 01 internal low power, loop off
// - 10 external, loop kept locked
// - 10 external low power, loop off
// - debug link clock in non-low-power modes
// - stop halts core and debug clocks, keeps enabled internal
// - stop keeps enabled external reference
// - relock after few divided reference cycles
// - switch after few new clock cycles
// - dead new source keeps old clock
// - bus divider acts at once
// - internal reference out while enabled
// - coarse trim reaches core in internal modes
// - trim values survive every reset
// - source select decode, 11 as 00
// - bus divider 1 to 8, reset 2
// - reference divider 1 to 128, reset 1
module csmc_top #(
  parameter int OSC_INIT_CYCLES = csmc_pkg::CSMC_OSC_INIT_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic FLL_CLOCK_IN,
  input wire logic IREF_CLOCK_IN,
  input wire logic EREF_CLOCK_IN,
  input wire logic STOP_REQ,
  input wire logic BACKGROUND_DEBUG_ACTIVE,
  output logic CORE_CLOCK_OUT,
  output logic DEBUG_LINK_CLOCK,
  output logic INTERNAL_REFERENCE_CLOCK_OUT,
  output logic EXTERNAL_REFERENCE_CLOCK_OUT,
  output logic FLL_ENABLE,
  output logic FLL_USE_INTERNAL,
  output logic FLL_FILTER_CLOCK,
  output logic [9:0] FLL_MULTIPLIER,
  output logic FLL_RELOCK,
  output logic [8:0] IREF_TRIM,
  output logic CORE_TRIM_ACTIVE,
  output logic OSC_ENABLE
);

  csmc_pkg::csmc_ctrl1_t ctrl1_reg;
  csmc_pkg::csmc_ctrl2_t ctrl2_reg;
  logic [7:0] coarse_reg;
  logic fine_reg;
  logic osc_ready_reg;
  logic osc_ready_next;
  logic [31:0] osc_cnt_reg;
  logic rd_done_reg;
  logic [31:0] rdata_reg;
  logic [6:0] ref_cnt_reg;
  logic ref_prev_reg;
  logic filt_reg;
  logic filt_prev_reg;
  logic int_sel_prev_reg;
  logic [2:0] relock_cnt_reg;
  logic relock_busy_reg;
  logic relock_pulse_reg;
  logic sel_prev_reg;
  logic [2:0] bus_cnt_reg;
  logic core_reg;
  logic link_reg;
  logic iref_out_reg;
  logic eref_out_reg;
  logic eref_prev_reg;
  logic sw_clk;
  logic [2:0] sw_cur;
  csmc_pkg::csmc_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM decode; reads wait one cycle so read data come from a flop
  wire logic hit_ctrl1 = (AVS_ADDRESS == csmc_pkg::CSMC_ADDR_CTRL1);
  wire logic hit_ctrl2 = (AVS_ADDRESS == csmc_pkg::CSMC_ADDR_CTRL2);
  wire logic hit_trim = (AVS_ADDRESS == csmc_pkg::CSMC_ADDR_TRIM);
  wire logic hit_stat = (AVS_ADDRESS == csmc_pkg::CSMC_ADDR_STAT);
  wire logic wr_lane0 = AVS_WRITE && AVS_BYTEENABLE[0];
  wire logic [7:0] wdata = AVS_WRITEDATA[7:0];
  wire csmc_pkg::csmc_stat_t stat_view;
  wire logic [7:0] rd_mux;

  // Read mux; unmapped addresses read as zero
  assign rd_mux = hit_ctrl1 ? ctrl1_reg :
                  hit_ctrl2 ? ctrl2_reg :
                  hit_trim ? coarse_reg :
                  hit_stat ? stat_view : 8'h00;
  assign AVS_WAITREQUEST = AVS_READ && !rd_done_reg;
  assign AVS_READDATA = rdata_reg;

  // Read answer register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_done_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      rd_done_reg <= AVS_READ && !rd_done_reg;
      rdata_reg <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  // reset state is loop engaged internal
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl1_reg <= csmc_pkg::CSMC_CTRL1_RST;
      ctrl2_reg <= csmc_pkg::CSMC_CTRL2_RST;
    end else begin
      if (wr_lane0 && hit_ctrl1) begin
        ctrl1_reg <= wdata;
      end
      if (wr_lane0 && hit_ctrl2) begin
        ctrl2_reg <= wdata;
      end
    end
  end

  // trim kept across reset, no reset branch
  always_ff @(posedge CLOCK) begin
    if (wr_lane0 && hit_trim) begin
      coarse_reg <= wdata;
    end
    if (wr_lane0 && hit_stat) begin
      fine_reg <= wdata[0];
    end
  end

  // fine bit is the trim LSB, larger means longer period
  assign IREF_TRIM = {coarse_reg, fine_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode
  // reserved select behaves as loop output
  wire logic [1:0] src_eff = (ctrl1_reg.src_sel == csmc_pkg::CSMC_SRC_RSVD) ?
                             csmc_pkg::CSMC_SRC_LOOP : ctrl1_reg.src_sel;
  wire logic low_power = ctrl2_reg.loop_pd && !BACKGROUND_DEBUG_ACTIVE;

  // mode from select, reference and low power
  always_comb begin
    if (src_eff == csmc_pkg::CSMC_SRC_IREF) begin
      mode = low_power ? csmc_pkg::CSMC_BYP_INT_LP : csmc_pkg::CSMC_BYP_INT;
    end else if (src_eff == csmc_pkg::CSMC_SRC_EREF) begin
      mode = low_power ? csmc_pkg::CSMC_BYP_EXT_LP : csmc_pkg::CSMC_BYP_EXT;
    end else begin
      mode = ctrl1_reg.int_ref_sel ? csmc_pkg::CSMC_LOOP_INT : csmc_pkg::CSMC_LOOP_EXT;
    end
  end

  wire logic mode_lp = (mode == csmc_pkg::CSMC_BYP_INT_LP) || (mode == csmc_pkg::CSMC_BYP_EXT_LP);
  wire logic mode_int = (mode == csmc_pkg::CSMC_LOOP_INT) || (mode == csmc_pkg::CSMC_BYP_INT) ||
                        (mode == csmc_pkg::CSMC_BYP_INT_LP);
  wire logic mode_ext = (mode == csmc_pkg::CSMC_LOOP_EXT) || (mode == csmc_pkg::CSMC_BYP_EXT) ||
                        (mode == csmc_pkg::CSMC_BYP_EXT_LP);
  wire logic [2:0] sel_req = (src_eff == csmc_pkg::CSMC_SRC_IREF) ? csmc_pkg::CSMC_SEL_IREF :
                             (src_eff == csmc_pkg::CSMC_SRC_EREF) ? csmc_pkg::CSMC_SEL_EREF :
                             csmc_pkg::CSMC_SEL_LOOP;

  // coarse trim reaches the core clock only here
  assign CORE_TRIM_ACTIVE = mode_int;

  ////////////////////////////////////////////////////////////////////////////////
  // Loop reference divider and relock control
  // loop off in low power bypass and in stop; running otherwise
  wire logic loop_run = !mode_lp && !STOP_REQ;
  wire logic ref_lvl = ctrl1_reg.int_ref_sel ? IREF_CLOCK_IN : EREF_CLOCK_IN;
  wire logic ref_rise = ref_lvl && !ref_prev_reg;
  wire logic [6:0] ref_cnt_inc = ref_cnt_reg + 7'h01;
  wire logic [7:0] ref_taps = {ref_cnt_inc, ref_lvl};
  wire logic filt_rise = filt_reg && !filt_prev_reg;

  // divide by two to the field value
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ref_cnt_reg <= '0;
      ref_prev_reg <= 1'b0;
      filt_reg <= 1'b0;
      filt_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_lvl;
      filt_prev_reg <= filt_reg;
      if (ctrl1_reg.ref_div == 3'h0) begin
        filt_reg <= ref_lvl;
      end else if (ref_rise) begin
        ref_cnt_reg <= ref_cnt_inc;
        filt_reg <= ref_taps[ctrl1_reg.ref_div];
      end
    end
  end

  // hold off locking for a few divided reference cycles
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      int_sel_prev_reg <= 1'b1;
      relock_cnt_reg <= '0;
      relock_busy_reg <= 1'b0;
      relock_pulse_reg <= 1'b0;
    end else begin
      int_sel_prev_reg <= ctrl1_reg.int_ref_sel;
      relock_pulse_reg <= 1'b0;
      if (ctrl1_reg.int_ref_sel != int_sel_prev_reg) begin
        relock_busy_reg <= 1'b1;
        relock_cnt_reg <= '0;
      end else if (relock_busy_reg && filt_rise) begin
        if (relock_cnt_reg == csmc_pkg::CSMC_RELOCK_EDGES - 3'h1) begin
          relock_busy_reg <= 1'b0;
          relock_pulse_reg <= 1'b1;
        end else begin
          relock_cnt_reg <= relock_cnt_reg + 3'h1;
        end
      end
    end
  end

  // loop told to lock at 512 times the filter clock
  assign FLL_MULTIPLIER = csmc_pkg::CSMC_LOOP_MULT;
  assign FLL_ENABLE = loop_run && !relock_busy_reg;
  assign FLL_USE_INTERNAL = ctrl1_reg.int_ref_sel;
  assign FLL_FILTER_CLOCK = filt_reg;
  assign FLL_RELOCK = relock_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator ready flag
  // external reference kept enabled in external modes
  wire logic ext_needed = ctrl2_reg.ext_out_en || mode_ext;
  wire logic eref_rise = EREF_CLOCK_IN && !eref_prev_reg;
  wire logic osc_done = (osc_cnt_reg >= 32'(OSC_INIT_CYCLES));
  assign OSC_ENABLE = ext_needed && (!STOP_REQ || ctrl2_reg.ext_stop_en);

  // set after startup, clear on enable drop; set wins
  always_comb begin
    osc_ready_next = osc_ready_reg;
    if (!ctrl2_reg.ext_out_en || !ctrl2_reg.osc_req) begin
      osc_ready_next = 1'b0;
    end
    if (ctrl2_reg.osc_req && ext_needed && osc_done) begin
      osc_ready_next = 1'b1;
    end
  end

  // Startup counter of oscillator edges
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      osc_cnt_reg <= '0;
      osc_ready_reg <= 1'b0;
      eref_prev_reg <= 1'b0;
    end else begin
      eref_prev_reg <= EREF_CLOCK_IN;
      osc_ready_reg <= osc_ready_next;
      if (!ctrl2_reg.osc_req || !ext_needed) begin
        osc_cnt_reg <= '0;
      end else if (eref_rise && !osc_done) begin
        osc_cnt_reg <= osc_cnt_reg + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock selection
  // synchronised glitch-free switch
  csmc_clk_switch u_switch (
    .clock(CLOCK),
    .rst(RST),
    .src({EREF_CLOCK_IN, IREF_CLOCK_IN, FLL_CLOCK_IN}),
    .req(sel_req),
    .clk_out(sw_clk),
    .cur(sw_cur)
  );

  // status from the switch, not the written select
  wire logic [1:0] mode_status = (sw_cur == csmc_pkg::CSMC_SEL_IREF) ? csmc_pkg::CSMC_SRC_IREF :
                                 (sw_cur == csmc_pkg::CSMC_SEL_EREF) ? csmc_pkg::CSMC_SRC_EREF :
                                 (sw_cur == csmc_pkg::CSMC_SEL_LOOP) ? csmc_pkg::CSMC_SRC_LOOP :
                                 csmc_pkg::CSMC_SRC_RSVD;
  assign stat_view = '{zero: 4'h0, mode_status: mode_status, osc_ready: osc_ready_reg,
                       fine_period: fine_reg};

  // bus divider tap picked live, no resync
  wire logic sel_rise = sw_clk && !sel_prev_reg;
  wire logic [2:0] bus_cnt_inc = bus_cnt_reg + 3'h1;
  wire logic [3:0] bus_taps = {bus_cnt_reg, sw_clk};

  // Divided core clock, halted in stop
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sel_prev_reg <= 1'b0;
      bus_cnt_reg <= '0;
      core_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sw_clk;
      if (sel_rise) begin
        bus_cnt_reg <= bus_cnt_inc;
      end
      core_reg <= !STOP_REQ && bus_taps[ctrl2_reg.bus_div];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Auxiliary clock outputs; gating is registered but can cut a pulse short when the gate changes mid-pulse
  // debug link clock unless low power bypass or stop
  // internal reference out, kept in stop if allowed
  // external reference out, kept in stop if allowed
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      link_reg <= 1'b0;
      iref_out_reg <= 1'b0;
      eref_out_reg <= 1'b0;
    end else begin
      link_reg <= loop_run && FLL_CLOCK_IN;
      iref_out_reg <= ctrl1_reg.int_out_en && IREF_CLOCK_IN && (!STOP_REQ || ctrl1_reg.int_stop_en);
      eref_out_reg <= ctrl2_reg.ext_out_en && EREF_CLOCK_IN && (!STOP_REQ || ctrl2_reg.ext_stop_en);
    end
  end

  assign CORE_CLOCK_OUT = core_reg;
  assign DEBUG_LINK_CLOCK = link_reg;
  assign INTERNAL_REFERENCE_CLOCK_OUT = iref_out_reg;
  assign EXTERNAL_REFERENCE_CLOCK_OUT = eref_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  status_after_reset_a: assert property ($fell(RST) |-> mode_status == csmc_pkg::CSMC_SRC_LOOP)
    else $error("status not loop after reset");
  status_not_instant_a: assert property (
    (wr_lane0 && hit_ctrl1 && !AVS_WAITREQUEST && wdata[7:6] != mode_status) |=> $stable(mode_status))
    else $error("status changed right after select write");
  link_off_lowpower_a: assert property (mode_lp |=> !DEBUG_LINK_CLOCK)
    else $error("debug link clock running in low power bypass");
  core_halt_stop_a: assert property (STOP_REQ[*2] |-> !CORE_CLOCK_OUT)
    else $error("core clock running in stop");
  eref_stop_keep_a: assert property (
    (STOP_REQ && ctrl2_reg.ext_out_en && ctrl2_reg.ext_stop_en) |=> EXTERNAL_REFERENCE_CLOCK_OUT == $past(EREF_CLOCK_IN))
    else $error("external reference not kept in stop");
  iref_follow_a: assert property (
    (ctrl1_reg.int_out_en && !STOP_REQ) |=> INTERNAL_REFERENCE_CLOCK_OUT == $past(IREF_CLOCK_IN))
    else $error("internal reference output not following");
  osc_clear_cause_a: assert property ($fell(osc_ready_reg) |->
    $past(!ctrl2_reg.ext_out_en || !ctrl2_reg.osc_req))
    else $error("oscillator flag cleared without cause");
  relock_hold_a: assert property ((ctrl1_reg.int_ref_sel != int_sel_prev_reg) |=> !FLL_ENABLE)
    else $error("loop enabled right after reference change");

endmodule : csmc_top

// ### testbench.sv
// Self-checking bench for the clock source mode control block.
// Assumes csmc_pkg and the design files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module testbench;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  logic FLL_CLOCK_IN = 1'b0, IREF_CLOCK_IN = 1'b0, EREF_CLOCK_IN = 1'b0;
  logic STOP_REQ = 1'b0, BACKGROUND_DEBUG_ACTIVE = 1'b0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, CORE_CLOCK_OUT, DEBUG_LINK_CLOCK, INTERNAL_REFERENCE_CLOCK_OUT;
  logic EXTERNAL_REFERENCE_CLOCK_OUT, FLL_ENABLE, FLL_USE_INTERNAL, FLL_FILTER_CLOCK, FLL_RELOCK;
  logic CORE_TRIM_ACTIVE, OSC_ENABLE;
  logic [9:0] FLL_MULTIPLIER;
  logic [8:0] IREF_TRIM;
  logic [31:0] q;
  logic [3:0] div_cnt = 4'h0;
  logic iref_run = 1'b1, eref_run = 1'b0;
  logic [1:0] seen = 2'h0;
  int checks = 0, n_mismatch = 0, cycles = 0;
  // Register rows: address, data, byte enable, expected read back
  localparam int NROW = 7;
  logic [3:0] row_a [NROW] = '{4'h4, 4'h4, 4'h0, 4'h8, 4'hc, 4'h2, 4'h0};
  logic [7:0] row_d [NROW] = '{8'h80, 8'hff, 8'h3c, 8'ha5, 8'hff, 8'hff, 8'h04};
  logic [3:0] row_be [NROW] = '{4'h1, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
  logic [7:0] row_q [NROW] = '{8'h80, 8'h80, 8'h3c, 8'ha5, 8'h01, 8'h00, 8'h04};

  csmc_top #(.OSC_INIT_CYCLES(8)) i_csmc_top (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLL_CLOCK_IN(FLL_CLOCK_IN),
    .IREF_CLOCK_IN(IREF_CLOCK_IN), .EREF_CLOCK_IN(EREF_CLOCK_IN), .STOP_REQ(STOP_REQ),
    .BACKGROUND_DEBUG_ACTIVE(BACKGROUND_DEBUG_ACTIVE), .CORE_CLOCK_OUT(CORE_CLOCK_OUT),
    .DEBUG_LINK_CLOCK(DEBUG_LINK_CLOCK), .INTERNAL_REFERENCE_CLOCK_OUT(INTERNAL_REFERENCE_CLOCK_OUT),
    .EXTERNAL_REFERENCE_CLOCK_OUT(EXTERNAL_REFERENCE_CLOCK_OUT), .FLL_ENABLE(FLL_ENABLE),
    .FLL_USE_INTERNAL(FLL_USE_INTERNAL), .FLL_FILTER_CLOCK(FLL_FILTER_CLOCK), .FLL_MULTIPLIER(FLL_MULTIPLIER),
    .FLL_RELOCK(FLL_RELOCK), .IREF_TRIM(IREF_TRIM), .CORE_TRIM_ACTIVE(CORE_TRIM_ACTIVE), .OSC_ENABLE(OSC_ENABLE));

  ////////////////////////////////////////////////////////////////////////////////
  // System clock, 4 ns period
  initial begin
    forever #2 CLOCK = ~CLOCK;
  end

  // Slow source clocks; a stopped source sits low so a dead oscillator is modelled
  always @(posedge CLOCK) begin
    div_cnt <= div_cnt + 4'h1;
    FLL_CLOCK_IN <= div_cnt[1];
    IREF_CLOCK_IN <= iref_run & div_cnt[2];
    EREF_CLOCK_IN <= eref_run & div_cnt[3];
  end

  // Sticky record of a relock pulse and of filter clock activity
  always @(posedge CLOCK) begin
    seen <= seen | {FLL_RELOCK, FLL_FILTER_CLOCK};
  end

  // Hang guard; the ceiling is well above the longest expected run
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon master: hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Poll the status register until the mode field shows m, bounded
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
      if (q[3:2] === m) break;
    end
    check({30'h0, q[3:2]}, {30'h0, m});
  endtask : wait_mode

  // Count high samples of the reference outputs and of the core and debug clocks
  task automatic watch(output logic [7:0] ir, output logic [7:0] er, output logic [7:0] other);
    ir = 8'h0;
    er = 8'h0;
    other = 8'h0;
    repeat (40) begin
      @(negedge CLOCK);
      ir = ir + {7'h0, INTERNAL_REFERENCE_CLOCK_OUT};
      er = er + {7'h0, EXTERNAL_REFERENCE_CLOCK_OUT};
      other = other + {7'h0, CORE_CLOCK_OUT | DEBUG_LINK_CLOCK};
    end
  endtask : watch

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] ir, er, ot;
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    bus(1'b0, csmc_pkg::CSMC_ADDR_CTRL1, 8'h0, 4'h0);
    check(q, {24'h0, csmc_pkg::CSMC_CTRL1_RST});
    bus(1'b0, csmc_pkg::CSMC_ADDR_CTRL2, 8'h0, 4'h0);
    check(q, {24'h0, csmc_pkg::CSMC_CTRL2_RST});
    bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
    check({29'h0, q[3:1]}, 32'h0);
    check({22'h0, FLL_MULTIPLIER}, 32'h200);
    $display("reset values done");
    // Write then read each row; refused and unmapped writes leave nothing behind
    for (int i = 0; i < NROW; i++) begin
      bus(1'b1, row_a[i], row_d[i], row_be[i]);
      bus(1'b0, row_a[i], 8'h0, 4'h0);
      check(q, {24'h0, row_q[i]});
    end
    check({23'h0, IREF_TRIM}, 32'h14b);
    // Trim must survive a second reset while control goes back to its defaults
    @(posedge CLOCK);
    RST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    bus(1'b0, csmc_pkg::CSMC_ADDR_CTRL2, 8'h0, 4'h0);
    check(q, 32'h40);
    check({23'h0, IREF_TRIM}, 32'h14b);
    $display("register table done");
    // Internal bypass: status lags the write, loop stays on until low power
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL1, 8'h44, 4'h1);
    bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
    check({30'h0, q[3:2]}, 32'h0);
    wait_mode(2'h1);
    check({30'h0, CORE_TRIM_ACTIVE, FLL_ENABLE}, 32'h3);
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL2, 8'h48, 4'h1);
    @(negedge CLOCK);
    check({31'h0, FLL_ENABLE}, 32'h0);
    @(posedge CLOCK);
    BACKGROUND_DEBUG_ACTIVE <= 1'b1;
    @(negedge CLOCK);
    check({31'h0, FLL_ENABLE}, 32'h1);
    @(posedge CLOCK);
    BACKGROUND_DEBUG_ACTIVE <= 1'b0;
    $display("internal bypass done");
    // External select with a dead source keeps the old clock
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL1, 8'h80, 4'h1);
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL2, 8'h46, 4'h1);
    repeat (1100) @(posedge CLOCK);
    bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
    check({30'h0, q[3:1]}, 32'h2);
    check({30'h0, FLL_USE_INTERNAL, OSC_ENABLE}, 32'h1);
    @(posedge CLOCK);
    eref_run <= 1'b1;
    wait_mode(2'h2);
    check({31'h0, CORE_TRIM_ACTIVE}, 32'h0);
    repeat (150) @(posedge CLOCK);
    bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
    check({31'h0, q[1]}, 32'h1);
    check({29'h0, seen, FLL_ENABLE}, 32'h7);
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL2, 8'h42, 4'h1);
    bus(1'b0, csmc_pkg::CSMC_ADDR_STAT, 8'h0, 4'h0);
    check({31'h0, q[1]}, 32'h0);
    $display("external switch done");
    // Stop: only references with both enables keep running
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL1, 8'h47, 4'h1);
    wait_mode(2'h1);
    @(posedge CLOCK);
    STOP_REQ <= 1'b1;
    repeat (3) @(posedge CLOCK);
    watch(ir, er, ot);
    check({31'h0, ir != 8'h0}, 32'h1);
    check({16'h0, er, ot}, 32'h0);
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL2, 8'h43, 4'h1);
    watch(ir, er, ot);
    check({31'h0, er != 8'h0}, 32'h1);
    @(posedge CLOCK);
    STOP_REQ <= 1'b0;
    $display("stop done");
    // Reserved select code behaves as loop output
    bus(1'b1, csmc_pkg::CSMC_ADDR_CTRL1, 8'hc4, 4'h1);
    wait_mode(2'h0);
    watch(ir, er, ot);
    check({31'h0, ot != 8'h0}, 32'h1);
    $display("reserved select done");
    print_verdict();
  end
endmodule : testbench
